// ===== logic/ascs_top.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "ascs_consts.svh"
module ascs_top
  import ascs_pkg::*;
(
  // System clock domain
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // Serial link, own clock
  input  wire logic                link_sclk,
  input  wire logic                link_cs_n,
  input  wire logic                link_din,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata,
  // Converter core and scan tables
  input  wire logic                conv_done,
  input  wire ascs_pkg::ascs_mask_t custom_mask,
  input  wire logic [8:0]          seq_length,
  input  wire logic [3:0]          seq_channel,
  output ascs_pkg::ascs_conv_s     conv,
  output logic [7:0]               seq_index,
  output logic [4:0]               fifo_results,
  output logic                     scan_busy
);

  // ----------------------------------------------------------------------
  // Link domain: shift in 16-bit frames
  // ----------------------------------------------------------------------
  logic [3:0]  bit_cnt;
  logic [14:0] shift;
  logic [15:0] link_word;
  logic        link_tgl;

  // Frame select resets the bit count, so a short frame never skews the next
  always_ff @(posedge link_sclk or posedge link_cs_n)
  begin
    if (link_cs_n)
      bit_cnt <= 4'h0;
    else
      bit_cnt <= bit_cnt + 4'h1;
  end

  // Word is held until the next full frame; toggle marks its arrival
  always_ff @(posedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift     <= 15'h0000;
      link_word <= 16'h0000;
      link_tgl  <= 1'b0;
    end
    else
    begin
      shift <= {shift[13:0], link_din};
      if (bit_cnt == `ASCS_FRAME_LAST)
      begin
        link_word <= {shift, link_din};
        link_tgl  <= ~link_tgl;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------------
  logic        tgl_s1;
  logic        tgl_s2;
  logic        tgl_s3;
  logic [15:0] frame;
  logic        frame_vld;

  // Toggle synchroniser; the word is stable long before the toggle lands
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else if (ce)
    begin
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // Capture the held word once per frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame     <= 16'h0000;
      frame_vld <= 1'b0;
    end
    else if (ce)
    begin
      frame_vld <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3)
        frame <= link_word;
    end
  end

  // ----------------------------------------------------------------------
  // Mode word decode
  // ----------------------------------------------------------------------
  ascs_mode_s mode;
  logic       narrow;
  logic       range_err;
  logic [3:0] scan_f;
  logic [3:0] ch_f;
  logic [3:0] top;
  logic       sel_ok;
  logic       is_null;
  logic       range_bad;
  logic       accept;
  logic       start_scan;
  logic [3:0] eff_scan;
  logic [3:0] eff_chan;

  assign scan_f    = frame[`ASCS_SCAN_HI:`ASCS_SCAN_LO];
  assign ch_f      = frame[`ASCS_CH_HI:`ASCS_CH_LO];   // [R08]
  assign top       = narrow ? `ASCS_TOP_NARROW : `ASCS_TOP_WIDE; // [R11]
  assign sel_ok    = !frame[`ASCS_SEL_BIT];           // [R10]
  // Zero and the top six codes leave the mode and bits 10:0 alone
  assign is_null   = (scan_f == `ASCS_M_KEEP) ||
                     (scan_f >= `ASCS_NULL_MIN);      // [R07] [R09]
  assign range_bad = sel_ok && !is_null && (ch_f > top); // [R11]
  assign accept    = frame_vld && sel_ok && !is_null && !range_bad;
  assign start_scan = frame_vld && sel_ok && !range_bad;
  assign eff_scan  = accept ? scan_f : mode.scan;
  assign eff_chan  = accept ? ch_f : mode.chan;

  // Mode register only moves on an accepted word
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode.scan <= `ASCS_RST_SCAN;
      mode.chan <= `ASCS_RST_CHAN;
    end
    else if (ce && accept)
    begin
      mode.scan <= scan_f;
      mode.chan <= ch_f;                              // [R08]
    end
  end

  // ----------------------------------------------------------------------
  // Channel masks per bit and result count
  // ----------------------------------------------------------------------
  ascs_mask_t le_mask;
  ascs_mask_t ge_mask;
  ascs_mask_t eq_mask;
  ascs_mask_t top_mask;
  ascs_mask_t next_mask;
  logic [4:0] pc [0:16];

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_bit
      assign le_mask[i]  = (4'(i) <= eff_chan);       // [R01]
      assign ge_mask[i]  = (4'(i) >= eff_chan);       // [R02] [R03]
      assign eq_mask[i]  = (4'(i) == eff_chan);
      assign top_mask[i] = (4'(i) <= top);            // [R11]
      assign pc[i+1]     = pc[i] + {4'h0, next_mask[i]};
    end
  endgenerate
  assign pc[0] = 5'h00;

  // Mode selects the inputs, clock source and averaging permission
  logic next_ext;
  logic next_avg;
  always_comb
  begin
    next_mask = 16'h0000;
    next_ext  = 1'b1;
    next_avg  = 1'b0;
    unique case (eff_scan)
      `ASCS_M_MANUAL:  next_mask = eq_mask & top_mask;
      `ASCS_M_REPEAT:
      begin
        next_mask = eq_mask & top_mask;
        next_ext  = 1'b0;
        next_avg  = 1'b1;
      end
      `ASCS_M_STD_INT:
      begin
        next_mask = le_mask & top_mask;
        next_ext  = 1'b0;
        next_avg  = 1'b1;
      end
      `ASCS_M_STD_EXT: next_mask = le_mask & top_mask;  // [R01]
      `ASCS_M_UP_INT:
      begin
        next_mask = ge_mask & top_mask;               // [R02]
        next_ext  = 1'b0;
        next_avg  = 1'b1;
      end
      `ASCS_M_UP_EXT:  next_mask = ge_mask & top_mask;  // [R03]
      `ASCS_M_CUS_INT:
      begin
        next_mask = custom_mask & top_mask;           // [R04]
        next_ext  = 1'b0;
        next_avg  = 1'b1;
      end
      `ASCS_M_CUS_EXT: next_mask = custom_mask & top_mask; // [R05]
      default:         next_mask = 16'h0000;          // [R06]
    endcase
  end

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  ascs_state_e state;
  ascs_mask_t  run_mask;
  logic [3:0]  run_scan;
  logic [3:0]  run_chan;
  logic [4:0]  cur;
  logic [8:0]  seq_cnt;
  logic [8:0]  seq_lim;
  logic        f_found;
  logic [3:0]  f_index;
  logic        run_seq;

  ascs_next_channel u_next (
    .mask  (run_mask),
    .from  (cur),
    .found (f_found),
    .index (f_index)
  );

  assign run_seq = (run_scan == `ASCS_M_SEQ);
  // Sequences longer than the table are cut at its depth
  assign seq_lim = (seq_length > `ASCS_SEQ_MAX) ? `ASCS_SEQ_MAX
                                                : seq_length; // [R06]

  logic go;
  assign go = (state == ASCS_SCAN) &&
              (run_seq ? (seq_cnt < seq_lim) : f_found);

  // A frame that lands mid-scan only updates the mode for the next scan
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= ASCS_IDLE;
      run_mask <= 16'h0000;
      run_scan <= `ASCS_RST_SCAN;
      run_chan <= `ASCS_RST_CHAN;
      cur      <= 5'h00;
      seq_cnt  <= 9'h000;
    end
    else if (ce)
    begin
      unique case (state)
        ASCS_IDLE:
          if (start_scan)
          begin
            state    <= ASCS_SCAN;
            run_mask <= next_mask;
            run_scan <= eff_scan;
            run_chan <= eff_chan;
            cur      <= 5'h00;
            seq_cnt  <= 9'h000;
          end
        ASCS_SCAN:
          if (!go)
            state <= ASCS_IDLE;
          else
          begin
            state   <= ASCS_WAIT;
            cur     <= {1'b0, f_index} + 5'h01;       // [R01] [R04]
            seq_cnt <= seq_cnt + 9'h001;              // [R06]
          end
        ASCS_WAIT:
          if (conv_done)
            state <= ASCS_SCAN;
        default: state <= ASCS_IDLE;
      endcase
    end
  end

  // Conversion request, one cycle per input; seq_index names the entry
  // that seq_channel must show at the next request, so it runs one ahead
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conv.start   <= 1'b0;
      conv.channel <= 4'h0;
      conv.ext_clk <= 1'b1;
      conv.avg_ok  <= 1'b0;
      seq_index    <= 8'h00;
    end
    else if (ce)
    begin
      conv.start <= go;
      if (go)
      begin
        conv.channel <= run_seq ? seq_channel : f_index;
        seq_index    <= seq_index + 8'h01;            // [R06]
      end
      else if (state == ASCS_IDLE && start_scan)
        seq_index <= 8'h00;
      // Clock source and averaging are fixed for a whole scan
      if (state == ASCS_IDLE && start_scan)
      begin
        conv.ext_clk <= next_ext;                     // [R01] [R05]
        conv.avg_ok  <= next_avg;                     // [R02] [R04]
      end
    end
  end

  // FIFO depth is fixed for a whole scan
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fifo_results <= 5'h00;
      scan_busy    <= 1'b0;
    end
    else if (ce)
    begin
      scan_busy <= (state != ASCS_IDLE) || start_scan;
      if (state == ASCS_IDLE && start_scan)
        fifo_results <= next_ext ? 5'h00 : pc[16];    // [R02]
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  logic clr_err;
  assign clr_err = reg_wr && (reg_addr == `ASCS_A_CONFIG) &&
                   reg_wdata[`ASCS_CFG_CLR_ERR];

  // Part variant select steers the top input
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      narrow <= 1'b0;
    else if (ce && reg_wr && reg_addr == `ASCS_A_CONFIG)
      narrow <= reg_wdata[`ASCS_CFG_NARROW];
  end

  // Sticky out-of-range flag; a new error beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      range_err <= 1'b0;
    else if (ce)
    begin
      if (frame_vld && range_bad)
        range_err <= 1'b1;                            // [R11]
      else if (clr_err)
        range_err <= 1'b0;
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (ce)
    begin
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `ASCS_A_STATUS:  reg_rdata <= {4'h0, scan_busy, range_err,
                                         conv.ext_clk, conv.avg_ok,
                                         mode.scan, mode.chan};
          `ASCS_A_CONFIG:  reg_rdata <= {15'h0000, narrow};
          `ASCS_A_RESULTS: reg_rdata <= {11'h000, fifo_results};
          default:         reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking a_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [3:0] last_ch;
  logic       first_ch;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_ch  <= 4'h0;
      first_ch <= 1'b1;
    end
    else if (ce)
    begin
      if (state == ASCS_IDLE)
        first_ch <= 1'b1;
      else if (conv.start)
      begin
        first_ch <= 1'b0;
        last_ch  <= conv.channel;
      end
    end
  end

  a_null_keep_mode: assert property (       // [R07]
    frame_vld && scan_f >= `ASCS_NULL_MIN |=> $stable(mode))
    else $error("null scan code changed the mode");
  a_zero_keep_mode: assert property (       // [R09]
    frame_vld && scan_f == `ASCS_M_KEEP |=> $stable(mode))
    else $error("zero scan code changed the mode");
  a_host_sel_bit: assert property (         // [R10]
    frame_vld && frame[`ASCS_SEL_BIT] |=> $stable(mode))
    else $error("word with bit 15 set changed the mode");
  a_chan_decode: assert property (          // [R08]
    ce && accept |=> mode.chan == $past(ch_f) && mode.scan == $past(scan_f))
    else $error("channel index not stored as sent");
  a_ext_no_avg: assert property (           // [R01]
    conv.start && (run_scan == `ASCS_M_STD_EXT || run_scan == `ASCS_M_UP_EXT
    || run_scan == `ASCS_M_CUS_EXT || run_seq)
    |-> conv.ext_clk && !conv.avg_ok)
    else $error("external scan without external clock");
  a_lower_range: assert property (          // [R01]
    conv.start && run_scan == `ASCS_M_STD_EXT |-> conv.channel <= run_chan)
    else $error("lower scan passed channel N");
  a_upper_range: assert property (          // [R03]
    conv.start && (run_scan == `ASCS_M_UP_EXT || run_scan == `ASCS_M_UP_INT)
    |-> conv.channel >= run_chan && conv.channel <= top)
    else $error("upper scan outside N to top");
  a_scan_order: assert property (           // [R04]
    conv.start && !run_seq && !first_ch |-> conv.channel > last_ch)
    else $error("scan not ascending");
  a_custom_member: assert property (        // [R05]
    conv.start && (run_scan == `ASCS_M_CUS_INT || run_scan == `ASCS_M_CUS_EXT)
    |-> run_mask[conv.channel])
    else $error("custom scan used unselected input");
  a_upper_fifo: assert property (           // [R02]
    $rose(scan_busy) && run_scan == `ASCS_M_UP_INT
    |-> fifo_results == {1'b0, top} + 5'h01 - {1'b0, run_chan})
    else $error("upper internal result count wrong");
  a_seq_bound: assert property (            // [R06]
    conv.start && run_seq |-> seq_cnt <= seq_lim && seq_cnt <= `ASCS_SEQ_MAX)
    else $error("sequence ran past its length");
  a_narrow_range: assert property (         // [R11]
    ce && frame_vld && range_bad |=> $stable(mode) && range_err)
    else $error("out-of-range channel accepted");

endmodule : ascs_top

// ===== logic/ascs_consts.svh
// Operation
// R01: Code 0100 scans 0 up to N ascending, external clock, no averaging.
// R02: Code 0101 scans N up to top input, internal clock; FIFO holds top+1-N.
// R03: Code 0110 scans N up to top ascending, external clock, no averaging.
// R04: Code 0111 scans custom set once ascending, internal clock, may average.
// R05: Code 1000 scans custom set upward, external clock, max 16, no average.
// R06: Code 1001 steps a stored list of up to 256, external clock, no average.
// R07: Codes 1010 to 1111 keep the current mode and ignore bits 10 to 0.
// R08: Channel field is a plain binary index, 0000 is input 0, 1111 input 15.
// R09: Code 0000 keeps the previous mode and ignores bits 10 to 0.
// R10: Host sends bit 15 as zero to address the mode-control word.
// R11: Eight-input parts top out at input 7; channel above 7 is out of range.
`ifndef ASCS_CONSTS_SVH
`define ASCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Mode-control word layout
// ----------------------------------------------------------------------
`define ASCS_SEL_BIT     15
`define ASCS_SCAN_HI     14
`define ASCS_SCAN_LO     11
`define ASCS_CH_HI       10
`define ASCS_CH_LO       7
`define ASCS_FRAME_LAST  4'hF

// ----------------------------------------------------------------------
// Scan codes
// ----------------------------------------------------------------------
`define ASCS_M_KEEP      4'h0
`define ASCS_M_MANUAL    4'h1
`define ASCS_M_REPEAT    4'h2
`define ASCS_M_STD_INT   4'h3
`define ASCS_M_STD_EXT   4'h4
`define ASCS_M_UP_INT    4'h5
`define ASCS_M_UP_EXT    4'h6
`define ASCS_M_CUS_INT   4'h7
`define ASCS_M_CUS_EXT   4'h8
`define ASCS_M_SEQ       4'h9
`define ASCS_NULL_MIN    4'hA

// ----------------------------------------------------------------------
// Input ranges, limits and reset values
// ----------------------------------------------------------------------
`define ASCS_TOP_WIDE    4'hF
`define ASCS_TOP_NARROW  4'h7
`define ASCS_SEQ_MAX     9'h100
`define ASCS_RST_SCAN    4'h1
`define ASCS_RST_CHAN    4'h0

// ----------------------------------------------------------------------
// Register port map
// ----------------------------------------------------------------------
`define ASCS_A_STATUS    4'h0
`define ASCS_A_CONFIG    4'h1
`define ASCS_A_RESULTS   4'h2
`define ASCS_CFG_NARROW  0
`define ASCS_CFG_CLR_ERR 1

`endif

// ===== logic/ascs_pkg.sv
package ascs_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ASCS_IDLE = 2'b00,
    ASCS_SCAN = 2'b01,
    ASCS_WAIT = 2'b10
  } ascs_state_e;

  // Stored scan mode and channel index
  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] chan;
  } ascs_mode_s;

  // Conversion request towards the converter core
  typedef struct packed {
    logic       start;
    logic [3:0] channel;
    logic       ext_clk;
    logic       avg_ok;
  } ascs_conv_s;

  typedef logic [15:0] ascs_mask_t;

endpackage : ascs_pkg

// ===== logic/ascs_next_channel.sv
`timescale 1ns/10ps
module ascs_next_channel
  import ascs_pkg::*;
(
  // Candidate inputs and start point
  input  wire ascs_pkg::ascs_mask_t mask,
  input  wire logic [4:0]           from,
  // Lowest selected input at or above the start point
  output logic                      found,
  output logic [3:0]                index
);

  logic [15:0] cand;

  // Keep only inputs at or above the start point
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_cand
      assign cand[i] = mask[i] && (5'(i) >= from);
    end
  endgenerate

  // Priority towards the lowest input keeps the scan ascending
  always_comb
  begin
    found = |cand;
    index = 4'h0;
    for (int k = 15; k >= 0; k--)
    begin
      if (cand[k])
        index = 4'(k);
    end
  end

endmodule : ascs_next_channel

// ===== verification/ascs_link_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------------
module ascs_link_host
(
  // Serial link towards the device
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_din
);
  // Idle: clock parked, frame deselected
  initial
  begin
    link_sclk = 1'b0;
    link_cs_n = 1'b0;
    link_din  = 1'b0;
    // A rising select clears the bit count before the first frame
    #2 link_cs_n = 1'b1;
  end

  // One frame, MSB first; the link clock runs only inside it
  task automatic send_frame(input logic [15:0] word);
    #1.7;
    link_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      link_din = word[i];
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
    #3 link_cs_n = 1'b1;
    // Released line shows no stale bit
    link_din = ~word[0];
  endtask : send_frame
endmodule : ascs_link_host

// ===== verification/ascs_top_bench.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Scan decode bench
// ----------------------------------------------------------------------
module ascs_top_bench;
  import ascs_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        ce;
  logic        link_sclk;
  logic        link_cs_n;
  logic        link_din;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        conv_done;
  ascs_mask_t  custom_mask;
  logic [8:0]  seq_length;
  logic [3:0]  seq_channel;
  ascs_conv_s  conv;
  logic [7:0]  seq_index;
  logic [4:0]  fifo_results;
  logic        scan_busy;
  logic [3:0]  seq_tab [16];
  logic [5:0]  conv_q [$];
  logic [31:0] rd_q [$];
  logic        rd_seen = 1'b0;
  logic [31:0] seed = 32'hc8a5_f2ed;
  int          num_errors = 0;
  int          num_checks = 0;
  int          done_cnt = 0;
  ascs_mask_t  msk;

  ascs_top dut (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_din(link_din),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .custom_mask(custom_mask), .seq_length(seq_length),
    .seq_channel(seq_channel), .conv(conv), .seq_index(seq_index),
    .fifo_results(fifo_results), .scan_busy(scan_busy)
  );
  ascs_link_host host (
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_din(link_din)
  );

  // Sequence table looked up by the entry index the block asks for
  assign seq_channel = seq_tab[seq_index[3:0]];

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  function automatic ascs_mask_t span(input int lo, input int hi);
    for (int i = 0; i < 16; i++)
      span[i] = (i >= lo) && (i <= hi);
  endfunction : span

  // Mode word with random don't-care bits below the channel field
  function automatic logic [15:0] mk(input logic [3:0] s,
                                     input logic [3:0] c);
    logic [31:0] r;
    r = next_rand();
    return {1'b0, s, c, r[6:0]};
  endfunction : mk

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : check

  task automatic complete_run();
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Note a masked expectation; the watcher compares it next cycle
  task automatic reg_read(input logic [3:0] a, input logic [15:0] m,
                          input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back({m, v});
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : reg_read

  task automatic expect_mask(input ascs_mask_t m, input logic ext,
                             input logic avg);
    for (int i = 0; i < 16; i++)
      if (m[i])
        conv_q.push_back({4'(i), ext, avg});
  endtask : expect_mask

  // Send a frame, then wait bounded for the scan to start and end
  task automatic run_scan(input logic [15:0] w);
    int n;
    int k;
    host.send_frame(w);
    for (n = 0; n < 40 && scan_busy !== 1'b1; n++)
      @(posedge clk);
    for (k = 0; k < 4000 && scan_busy !== 1'b0; k++)
      @(posedge clk);
    if (n == 40 || k == 4000)
    begin
      num_errors++;
      complete_run();
    end
    @(posedge clk);
    check("pending conversions", 16'(conv_q.size()), 16'h0000);
  endtask : run_scan

  // Frame that must not start a scan; the watcher flags any start
  task automatic frame_quiet(input logic [15:0] w);
    host.send_frame(w);
    repeat (16) @(posedge clk);
  endtask : frame_quiet

  // Converter stand-in: finishes each conversion after 1 to 3 cycles
  always @(posedge clk)
  begin
    conv_done <= (done_cnt == 1);
    if (conv.start === 1'b1)
      done_cnt <= 1 + int'(next_rand() % 3);
    else if (done_cnt > 0)
      done_cnt <= done_cnt - 1;
  end

  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk)
  begin
    logic [31:0] r;
    logic [5:0]  e;
    if (rd_seen)
    begin
      r = rd_q.pop_front();
      check("reg_rdata", reg_rdata & r[31:16], r[15:0]);
    end
    rd_seen <= reg_rd;
    if (conv.start === 1'b1)
    begin
      e = (conv_q.size() > 0) ? conv_q.pop_front() : 6'bx;
      check("conversion", {10'h000, conv.channel, conv.ext_clk,
      conv.avg_ok}, {10'h000, e});
    end
  end

  initial
  begin
    reset_n = 1'b1;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conv_done = 1'b0;
    custom_mask = 16'h0000;
    seq_length = 9'h000;
    for (int i = 0; i < 16; i++)
      seq_tab[i] = 4'(next_rand());
    seq_tab[1] = seq_tab[0];
    // A real falling edge lets every asynchronous reset take hold
    #1 reset_n = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    reg_read(4'hF, 16'hFFFF, 16'h0000);
    expect_mask(span(0, 3), 1'b1, 1'b0);
    run_scan(mk(4'h4, 4'h3));
    reg_read(4'h2, 16'h001F, 16'h0000);
    expect_mask(span(13, 15), 1'b0, 1'b1);
    run_scan(mk(4'h5, 4'hD));
    reg_read(4'h2, 16'h001F, 16'h0003);
    expect_mask(span(15, 15), 1'b1, 1'b0);
    run_scan(mk(4'h6, 4'hF));
    msk = ascs_mask_t'(next_rand()) | 16'h0100;
    custom_mask <= msk;
    expect_mask(msk, 1'b0, 1'b1);
    run_scan(mk(4'h7, 4'h0));
    reg_read(4'h2, 16'h001F, 16'($countones(msk)));
    msk = ascs_mask_t'(next_rand()) | 16'h8001;
    custom_mask <= msk;
    expect_mask(msk, 1'b1, 1'b0);
    run_scan(mk(4'h8, 4'h0));
    seq_length <= 9'h003;
    for (int i = 0; i < 3; i++)
      conv_q.push_back({seq_tab[i], 1'b1, 1'b0});
    run_scan(mk(4'h9, 4'h0));
    // Standard internal, manual, repeat and standard external modes
    expect_mask(span(0, 2), 1'b0, 1'b1);
    run_scan(mk(4'h3, 4'h2));
    reg_read(4'h2, 16'h001F, 16'h0003);
    expect_mask(span(4, 4), 1'b1, 1'b0);
    run_scan(mk(4'h1, 4'h4));
    expect_mask(span(6, 6), 1'b0, 1'b1);
    run_scan(mk(4'h2, 4'h6));
    expect_mask(span(0, 2), 1'b1, 1'b0);
    run_scan(mk(4'h4, 4'h2));
    // Keep codes re-run the stored scan while idle
    for (int c = 9; c < 16; c++)
    begin
      expect_mask(span(0, 2), 1'b1, 1'b0);
      run_scan({1'b0, (c == 9) ? 4'h0 : 4'(c),
                11'(next_rand())});
      reg_read(4'h0, 16'h00FF, 16'h0042);
    end
    frame_quiet(16'h8000 | mk(4'h5, 4'h1));
    reg_read(4'h0, 16'h00FF, 16'h0042);
    // Eight-input part: out-of-range channel refused, then cleared
    reg_write(4'h1, 16'h0001);
    reg_read(4'h1, 16'h0003, 16'h0001);
    // Strobes are ignored while the clock enable is low
    ce <= 1'b0;
    reg_write(4'h1, 16'h0000);
    ce <= 1'b1;
    reg_read(4'h1, 16'h0003, 16'h0001);
    frame_quiet(mk(4'h6, 4'h9));
    reg_read(4'h0, 16'h04FF, 16'h0442);
    reg_write(4'h1, 16'h0003);
    reg_read(4'h0, 16'h04FF, 16'h0042);
    expect_mask(span(5, 7), 1'b1, 1'b0);
    run_scan(mk(4'h6, 4'h5));
    expect_mask(span(5, 7), 1'b0, 1'b1);
    run_scan(mk(4'h5, 4'h5));
    reg_read(4'h2, 16'h001F, 16'h0003);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : ascs_top_bench
